// *** hdl/cbt_bit_timing.sv ***
// Purpose: CAN bit timing: quantum prescaler, segments, sampling, sync
// Assumes: can_rx synchronous to sys_clk; AHB-Lite slave, zero wait states
// Notes:   Config writes are ignored while the run bit is set
`timescale 1ns/10ps
`include "cbt_defines.svh"

module cbt_bit_timing import cbt_pkg::*; (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        can_rx,
    input  wire logic        bus_idle,
    input  wire logic        tx_bit,
    output logic             can_tx,
    output logic             rx_bit,
    output logic             bit_start,
    output logic             sample_strobe
);

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic [7:0]  cfg1_q, cfg1_d, cfg2_q, cfg2_d, cfg3_q, cfg3_d;
    logic        run_q, run_d, wr_q, wr_d;
    logic [7:0]  addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic        acc;
    cbt_seg_t    st_q;

    assign acc = hsel && hready && htrans[1];

    always_comb begin
        cfg1_d  = cfg1_q;
        cfg2_d  = cfg2_q;
        cfg3_d  = cfg3_q;
        run_d   = run_q;
        wr_d    = acc && hwrite;
        addr_d  = acc ? haddr[7:0] : addr_q;
        rdata_d = rdata_q;
        if (wr_q) begin
            // Timing fields are frozen while the engine runs
            if (addr_q == `CBT_OFF_CFG1 && !run_q) cfg1_d = hwdata[7:0];
            if (addr_q == `CBT_OFF_CFG2 && !run_q) cfg2_d = hwdata[7:0];
            if (addr_q == `CBT_OFF_CFG3 && !run_q) cfg3_d = hwdata[7:0];
            if (addr_q == `CBT_OFF_CTRL) run_d = hwdata[`CBT_RUN_BIT];
        end
        // Read from next values so a write just before is seen
        if (acc && !hwrite) begin
            case (haddr[7:0])
                `CBT_OFF_CFG1: rdata_d = {24'h000000, cfg1_d};
                `CBT_OFF_CFG2: rdata_d = {24'h000000, cfg2_d};
                `CBT_OFF_CFG3: rdata_d = {24'h000000, cfg3_d};
                `CBT_OFF_CTRL: rdata_d = {31'h00000000, run_d};
                `CBT_OFF_STAT: rdata_d = {24'h000000, can_tx, rx_bit, run_q, 1'b0, st_q};
                default:       rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg1_q    <= `CBT_CFG_RST;
            cfg2_q    <= `CBT_CFG_RST;
            cfg3_q    <= `CBT_CFG_RST;
            run_q     <= 1'b0;
            wr_q      <= 1'b0;
            addr_q    <= 8'h00;
            rdata_q   <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (clk_en) begin
            cfg1_q    <= cfg1_d;
            cfg2_q    <= cfg2_d;
            cfg3_q    <= cfg3_d;
            run_q     <= run_d;
            wr_q      <= wr_d;
            addr_q    <= addr_d;
            rdata_q   <= rdata_d;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
    assign hrdata = rdata_q;

    // ----------------------------------------------------------------
    // Segment lengths
    // ----------------------------------------------------------------
    logic [5:0] presc;
    logic [3:0] jump_len, prop_len, pre_len, post_prog, post_len;
    logic       triple_sel, src_sel;

    assign presc      = cfg1_q[`CBT_PRESC_MSB:`CBT_PRESC_LSB];
    assign jump_len   = {2'b00, cfg1_q[`CBT_JUMP_MSB:`CBT_JUMP_LSB]} + 4'h1;
    assign prop_len   = {1'b0, cfg2_q[`CBT_DELAY_MSB:`CBT_DELAY_LSB]} + 4'h1;
    assign pre_len    = {1'b0, cfg2_q[`CBT_PRE_MSB:`CBT_PRE_LSB]} + 4'h1;
    assign post_prog  = {1'b0, cfg3_q[`CBT_POST_MSB:`CBT_POST_LSB]} + 4'h1;
    assign triple_sel = cfg2_q[`CBT_TRIPLE_BIT];
    assign src_sel    = cfg2_q[`CBT_SRC_BIT];

    always_comb begin
        // Never below the processing interval
        if (src_sel) begin
            post_len = (post_prog > `CBT_PROC_TQ) ? post_prog : `CBT_PROC_TQ;
        end else begin
            post_len = (pre_len > `CBT_PROC_TQ) ? pre_len : `CBT_PROC_TQ;
        end
    end

    // ----------------------------------------------------------------
    // Timing engine
    // ----------------------------------------------------------------
    cbt_seg_t   st_d;
    logic [5:0] pre_q, pre_d;
    logic       half_q, half_d, half_tick, tq_tick;
    logic [3:0] seg_q, seg_d, ext_q, ext_d, cut_q, cut_d;
    logic [3:0] pre_eff, post_eff, rem;
    logic [4:0] err;
    logic       synced_q, synced_d, rxp_q, fall, hard, restart;
    logic [1:0] hist_q, hist_d;
    logic       rxb_q, rxb_d, tx_q, tx_d, bs_d, sp_d, vote;

    assign half_tick = clk_en && run_q && pre_q == presc;
    assign tq_tick   = half_tick && half_q;
    assign pre_eff   = pre_len + ext_q;
    assign post_eff  = post_len - cut_q;
    assign rem       = post_eff - seg_q;
    assign fall      = rxp_q && !can_rx && rxb_q && !synced_q && run_q;
    assign hard      = fall && bus_idle;
    assign vote      = (hist_q[0] & hist_q[1]) | (hist_q[0] & can_rx) | (hist_q[1] & can_rx);

    always_comb begin
        st_d     = st_q;
        pre_d    = half_tick ? 6'h00 : pre_q + 6'h01;
        half_d   = half_tick ? !half_q : half_q;
        seg_d    = seg_q;
        ext_d    = ext_q;
        cut_d    = cut_q;
        synced_d = synced_q;
        hist_d   = half_tick ? {hist_q[0], can_rx} : hist_q;
        rxb_d    = rxb_q;
        tx_d     = tx_q;
        bs_d     = 1'b0;
        sp_d     = 1'b0;
        restart  = 1'b0;
        err      = 5'h00;
        if (st_q == CBT_PROP) begin
            err = {1'b0, seg_q} + 5'h01;
        end else if (st_q == CBT_PH1) begin
            err = {1'b0, prop_len} + {1'b0, seg_q} + 5'h01;
        end
        if (!run_q) begin
            st_d   = CBT_SYNC;
            pre_d  = 6'h00;
            half_d = 1'b0;
            seg_d  = 4'h0;
            ext_d  = 4'h0;
            cut_d  = 4'h0;
            tx_d   = `CBT_RECESSIVE;
            rxb_d  = `CBT_RECESSIVE;
        end else if (hard) begin
            restart = 1'b1;
        end else if (fall && (st_q == CBT_PROP || st_q == CBT_PH1) && tx_q) begin
            // Late edge: stretch the pre-sample span, no more than jump width
            synced_d = 1'b1;
            ext_d = (err > {1'b0, jump_len}) ? jump_len : err[3:0];
        end else if (fall && st_q == CBT_PH2) begin
            synced_d = 1'b1;
            if (rem <= jump_len) begin
                restart = 1'b1;
            end else begin
                cut_d = jump_len;
            end
        end
        if (restart) begin
            st_d     = CBT_SYNC;
            pre_d    = 6'h00;
            half_d   = 1'b0;
            seg_d    = 4'h0;
            ext_d    = 4'h0;
            cut_d    = 4'h0;
            synced_d = 1'b1;
            bs_d     = 1'b1;
            tx_d     = tx_bit;
        end else if (tq_tick) begin
            seg_d = seg_q + 4'h1;
            case (st_q)
                CBT_SYNC: begin
                    st_d  = CBT_PROP;
                    seg_d = 4'h0;
                end
                CBT_PROP: begin
                    if (seg_q == prop_len - 4'h1) begin
                        st_d  = CBT_PH1;
                        seg_d = 4'h0;
                    end
                end
                CBT_PH1: begin
                    if (seg_q == pre_eff - 4'h1) begin
                        // Processing interval opens here, inside the post span
                        st_d  = CBT_PH2;
                        seg_d = 4'h0;
                        sp_d  = 1'b1;
                        rxb_d = triple_sel ? vote : can_rx;
                    end
                end
                CBT_PH2: begin
                    if (seg_q == post_eff - 4'h1) begin
                        st_d     = CBT_SYNC;
                        seg_d    = 4'h0;
                        ext_d    = 4'h0;
                        cut_d    = 4'h0;
                        synced_d = 1'b0;
                        bs_d     = 1'b1;
                        tx_d     = tx_bit;
                    end
                end
                default: begin
                    st_d  = CBT_SYNC;
                    seg_d = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q          <= CBT_SYNC;
            pre_q         <= 6'h00;
            half_q        <= 1'b0;
            seg_q         <= 4'h0;
            ext_q         <= 4'h0;
            cut_q         <= 4'h0;
            synced_q      <= 1'b0;
            hist_q        <= 2'b11;
            rxp_q         <= `CBT_RECESSIVE;
            rxb_q         <= `CBT_RECESSIVE;
            tx_q          <= `CBT_RECESSIVE;
            bit_start     <= 1'b0;
            sample_strobe <= 1'b0;
        end else if (clk_en) begin
            st_q          <= st_d;
            pre_q         <= pre_d;
            half_q        <= half_d;
            seg_q         <= seg_d;
            ext_q         <= ext_d;
            cut_q         <= cut_d;
            synced_q      <= synced_d;
            hist_q        <= hist_d;
            rxp_q         <= can_rx;
            rxb_q         <= rxb_d;
            tx_q          <= tx_d;
            bit_start     <= bs_d;
            sample_strobe <= sp_d;
        end
    end
    assign can_tx = tx_q;
    assign rx_bit = rxb_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [7:0] clk_cnt_q;
    logic [4:0] tq_cnt_q;
    logic [4:0] nominal;

    assign nominal = 5'h01 + {1'b0, prop_len} + {1'b0, pre_len} + {1'b0, post_len};

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_cnt_q <= 8'h00;
            tq_cnt_q  <= 5'h00;
        end else if (clk_en) begin
            clk_cnt_q <= (tq_tick || !run_q || restart) ? 8'h00 : clk_cnt_q + 8'h01;
            tq_cnt_q  <= (bs_d || !run_q) ? 5'h00 : tq_cnt_q + {4'h0, tq_tick};
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_tq_period;
        tq_tick && $past(run_q) && $past(tq_tick || restart) == 1'b0 && clk_cnt_q != 8'h00
            |-> {1'b0, clk_cnt_q} + 9'h001 == {2'b00, presc, 1'b0} + 9'h002;
    endproperty
    a_tq_period: assert property (p_tq_period) else $error("quantum length wrong");

    property p_bit_len;
        tq_tick && st_q == CBT_PH2 && bs_d && !synced_q && !restart
            |-> tq_cnt_q + 5'h01 == nominal && nominal >= `CBT_BIT_MIN_TQ - 5'h03
                && nominal <= `CBT_BIT_MAX_TQ;
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("bit length wrong");

    property p_sync_one;
        clk_en && tq_tick && !restart && st_q == CBT_SYNC |=> st_q == CBT_PROP;
    endproperty
    a_sync_one: assert property (p_sync_one) else $error("sync not one quantum");

    property p_prop_end;
        clk_en && tq_tick && !restart && st_q == CBT_PROP && seg_q == prop_len - 4'h1
            |=> st_q == CBT_PH1 && seg_q == 4'h0;
    endproperty
    a_prop_end: assert property (p_prop_end) else $error("delay span end wrong");

    property p_single;
        clk_en && sp_d && !triple_sel |=> rxb_q == $past(can_rx) ##0 sample_strobe;
    endproperty
    a_single: assert property (p_single) else $error("single sample wrong");

    property p_tx_edge;
        clk_en && tx_q != $past(tx_q) && $past(run_q) |-> bit_start;
    endproperty
    a_tx_edge: assert property (p_tx_edge) else $error("tx changed mid bit");

    property p_frozen;
        run_q && clk_en |=> $stable(cfg1_q) && $stable(cfg2_q) && $stable(cfg3_q);
    endproperty
    a_frozen: assert property (p_frozen) else $error("timing changed while running");

    property p_hard;
        clk_en && hard |=> st_q == CBT_SYNC && seg_q == 4'h0 && bit_start ##1 !bit_start;
    endproperty
    a_hard: assert property (p_hard) else $error("hard sync failed");

    property p_post_min;
        run_q && st_q == CBT_PH2 && cut_q == 4'h0 |-> post_eff >= `CBT_PROC_TQ;
    endproperty
    a_post_min: assert property (p_post_min) else $error("post span too short");

    c_hard:   cover property (clk_en && hard);
    c_stretch: cover property (clk_en && ext_d != 4'h0 && ext_q == 4'h0);
    c_cut:    cover property (clk_en && cut_d != 4'h0);
    c_vote:   cover property (clk_en && sp_d && triple_sel);

endmodule

// *** hdl/cbt_defines.svh ***
// Purpose: Register offsets, field positions and fixed counts of the bit timer
// Assumes: Included by the bit timer itself and by its bench
// Notes:   Definitions only
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CBT_OFF_CFG1    8'h00
`define CBT_OFF_CFG2    8'h04
`define CBT_OFF_CFG3    8'h08
`define CBT_OFF_CTRL    8'h0c
`define CBT_OFF_STAT    8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CBT_PRESC_LSB   0
`define CBT_PRESC_MSB   5
`define CBT_JUMP_LSB    6
`define CBT_JUMP_MSB    7
`define CBT_DELAY_LSB   0
`define CBT_DELAY_MSB   2
`define CBT_PRE_LSB     3
`define CBT_PRE_MSB     5
`define CBT_TRIPLE_BIT  6
`define CBT_SRC_BIT     7
`define CBT_POST_LSB    0
`define CBT_POST_MSB    2
`define CBT_RUN_BIT     0

// ----------------------------------------------------------------
// Reset values and fixed counts
// ----------------------------------------------------------------
`define CBT_CFG_RST     8'h00
`define CBT_PROC_TQ     4'h2
`define CBT_RECESSIVE   1'b1
`define CBT_BIT_MIN_TQ  5'h08
`define CBT_BIT_MAX_TQ  5'h19

`endif

// *** hdl/cbt_pkg.sv ***
// Purpose: Types shared by the bit timer
// Assumes: Nothing
// Notes:   One-hot segment codes
package cbt_pkg;
    typedef enum logic [3:0] {
        CBT_SYNC = 4'b0001,
        CBT_PROP = 4'b0010,
        CBT_PH1  = 4'b0100,
        CBT_PH2  = 4'b1000
    } cbt_seg_t;
endpackage

// *** verification/can_bit_timing_tb.sv ***
// Purpose: Self-checking bench for the bit timer
// Assumes: One bus slave, so hready follows hreadyout
// Notes:   Monitors pop expected values from queues filled by the driver
`timescale 1ns/10ps
`include "cbt_defines.svh"
module can_bit_timing_tb;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        clk_en = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, can_tx, rx_bit, bit_start, sample_strobe;
    logic        bus_idle = 1'b1;
    logic        tx_bit = 1'b1;
    logic        node_drive;
    logic        tx_mode = 1'b0;
    logic        rd_ph = 1'b0;
    logic        tx_prev = 1'b1;
    int          fails = 0;
    int          num_checks = 0;
    int          cnt_bs = 0;
    int          cnt_ss = 0;
    logic [31:0] rd_q[$];
    logic        rx_q[$];
    logic        tx_q[$];
    int          pre_q[$];
    int          post_q[$];
    wire         can_rx = node_drive & can_tx;

    always #2.5 sys_clk = ~sys_clk;

    cbt_bit_timing i_cbt_bit_timing (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .can_rx(can_rx), .bus_idle(bus_idle), .tx_bit(tx_bit),
        .can_tx(can_tx), .rx_bit(rx_bit), .bit_start(bit_start),
        .sample_strobe(sample_strobe));

    cbt_can_node i_cbt_can_node (.sys_clk(sys_clk), .node_drive(node_drive));

    // ----------------------------------------------------------------
    // Compare and report
    // ----------------------------------------------------------------
    task automatic report(input string msg);
        fails++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) report($sformatf("read %h want %h", got, exp));
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) report($sformatf("level %b want %b", got, exp));
    endtask
    task automatic chk_cnt(input int got, input int exp);
        num_checks++;
        if (got != exp) report($sformatf("span %0d clocks want %0d", got, exp));
    endtask
    task automatic final_report();
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // sel 0: bit start, 1: sample strobe, 2: receive queue drained
    task automatic wait_for(input int sel);
        for (int i = 0; i < 20000; i++) begin
            @(negedge sys_clk);
            if ((sel == 0 && bit_start === 1'b1) || (sel == 1 && sample_strobe === 1'b1)
                || (sel == 2 && rx_q.size() == 0)) return;
        end
        report("wait ran out");
        final_report();
    endtask
    task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] d);
        int n;
        if (!wr) rd_q.push_back(d);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            do begin
                @(posedge sys_clk);
                n++;
            end while (hreadyout !== 1'b1 && n < 1000);
            if (n >= 1000) begin
                report("bus hang");
                final_report();
            end
            hsel   <= 1'b0;
            htrans <= 2'b00;
            hwdata <= wr ? d : 32'h0;
        end
    endtask
    // Config only lands while stopped, so stop first
    task automatic setup(input int p, pr, pre, po, src, ts, jw);
        ahb(`CBT_OFF_CTRL, 1'b1, 32'h0);
        ahb(`CBT_OFF_CFG1, 1'b1, {24'h0, 2'(jw - 1), 6'(p)});
        ahb(`CBT_OFF_CFG2, 1'b1, {24'h0, 1'(src), 1'(ts), 3'(pre - 1), 3'(pr - 1)});
        ahb(`CBT_OFF_CFG3, 1'b1, {29'h0, 3'(po - 1)});
        ahb(`CBT_OFF_CTRL, 1'b1, 32'h1);
    endtask

    // ----------------------------------------------------------------
    // Monitors
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rd_ph && hreadyout === 1'b1 && rd_q.size() > 0) chk_word(hrdata, rd_q.pop_front());
        if (hreadyout === 1'b1) rd_ph = hsel && htrans[1] && !hwrite;
    end

    always @(negedge sys_clk) begin
        cnt_bs++;
        cnt_ss++;
        if (sample_strobe === 1'b1) begin
            if (pre_q.size() > 0) chk_cnt(cnt_bs, pre_q.pop_front());
            if (rx_q.size() > 0) chk_bit(rx_bit, rx_q.pop_front());
            if (tx_mode) chk_bit(rx_bit, can_tx);
            cnt_ss = 0;
        end
        if (bit_start === 1'b1) begin
            if (post_q.size() > 0) chk_cnt(cnt_ss, post_q.pop_front());
            if (tx_q.size() > 0) chk_bit(can_tx, tx_q.pop_front());
            cnt_bs = 0;
        end else if (tx_mode && can_tx !== tx_prev) begin
            report("transmit level moved inside a bit");
        end
        tx_prev = can_tx;
    end

    initial begin
        int          cf[4][5];
        int          tq, post, len, run;
        logic [31:0] v[3];
        logic [63:0] fr;
        logic        b;
        void'($urandom(24));
        // Prescalers keep every bit at 200 clocks or more, i.e. at most 1 Mb/s
        cf = '{'{12, 1, 3, 1, 0}, '{11, 5, 1, 1, 1}, '{4, 8, 8, 8, 1}, '{6, 2, 7, 6, 1}};
        repeat (20) @(posedge sys_clk);
        chk_bit(can_tx, `CBT_RECESSIVE);
        chk_bit(hresp, 1'b0);
        rst_b <= 1'b1;
        for (int a = 0; a < 5; a++) ahb((a == 4) ? 8'h14 : 8'(a * 4), 1'b0, 32'h0);
        for (int r = 0; r < 3; r++) begin
            v[r] = $urandom();
            ahb(8'(r * 4), 1'b1, v[r]);
            ahb(8'(r * 4), 1'b0, {24'h0, v[r][7:0]});
        end
        ahb(`CBT_OFF_CTRL, 1'b1, 32'hffff_ff01);
        ahb(`CBT_OFF_CTRL, 1'b0, 32'h1);
        // Writes while running must bounce
        ahb(`CBT_OFF_CFG1, 1'b1, ~v[0]);
        ahb(`CBT_OFF_CFG1, 1'b0, {24'h0, v[0][7:0]});
        for (int c = 0; c < 4; c++) begin
            if (c == 3) cf[c][0] = $urandom_range(63, 6);
            setup(cf[c][0], cf[c][1], cf[c][2], cf[c][3], cf[c][4], c % 2, 1);
            tq = 2 * (cf[c][0] + 1);
            post = cf[c][4] ? cf[c][3] : cf[c][2];
            if (post < `CBT_PROC_TQ) post = `CBT_PROC_TQ;
            wait_for(0);
            @(posedge sys_clk);
            repeat (3) begin
                pre_q.push_back(tq * (1 + cf[c][1] + cf[c][2]));
                post_q.push_back(tq * post);
            end
            repeat (3) wait_for(0);
        end
        // Frames at nominal, slow and fast remote rate
        for (int f = 0; f < 3; f++) begin
            setup(9, 2, 4, 3, 1, f == 1, 2);
            len = 0;
            run = 0;
            for (int i = 0; i < 24; i++) begin
                b = (i == 0) ? 1'b0 : 1'($urandom_range(1));
                if (run == 5) b = ~fr[len - 1];
                run = (len > 0 && b == fr[len - 1]) ? run + 1 : 1;
                fr[len] = b;
                len++;
            end
            wait_for(1);
            @(posedge sys_clk);
            for (int i = 0; i < len; i++) rx_q.push_back(fr[i]);
            fork
                i_cbt_can_node.send(fr, len, 200 + 4 * (f == 1) - 4 * (f == 2));
                begin
                    repeat (8) @(posedge sys_clk);
                    bus_idle <= 1'b0;
                end
            join
            bus_idle <= 1'b1;
            wait_for(2);
        end
        setup(9, 2, 4, 3, 1, 0, 2);
        // Own frame on the wire: bus is busy, so no hard sync on own edges
        bus_idle <= 1'b0;
        tx_mode <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            b = 1'($urandom_range(1));
            @(posedge sys_clk);
            tx_bit <= b;
            tx_q.push_back(b);
            wait_for(0);
            repeat (3) @(posedge sys_clk);
        end
        // Enable low must freeze the timer longer than one whole bit
        clk_en <= 1'b0;
        @(negedge sys_clk);
        b = can_tx;
        repeat (300) @(negedge sys_clk);
        chk_bit(can_tx, b);
        chk_bit(1'(cnt_bs > 300), 1'b1);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        tx_mode <= 1'b0;
        final_report();
    end
endmodule

// *** verification/cbt_can_node.sv ***
// Purpose: Remote node that puts frames onto the shared bus
// Assumes: Bus pulled up, so released means recessive 1
// Notes:   Bit period per frame in clocks; off-nominal periods force resync
`timescale 1ns/10ps
module cbt_can_node (
    input  wire logic sys_clk,
    output logic      node_drive
);
    initial node_drive = 1'b1;

    // Bits go out LSB first, one per fixed period
    task automatic send(input logic [63:0] bits, input int len, input int per);
        for (int i = 0; i < len; i++) begin
            node_drive <= bits[i];
            repeat (per) @(posedge sys_clk);
        end
        node_drive <= 1'b1;
    endtask
endmodule
